//--- tsc_defs.vh
// Register numbers, field positions, masks and reset values of the tile status bank
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// ==========================================================================
// Register numbers
`define TSC_REG_EVT_BASE      8'h01
`define TSC_REG_TILE_CTRL     8'h02
`define TSC_REG_BOOT_STATUS   8'h03
`define TSC_REG_SECURITY      8'h05
`define TSC_REG_OSC_CTRL      8'h06
`define TSC_REG_OSC_COUNT0    8'h07

// ==========================================================================
// Event vector base
`define TSC_VB_MSB            31
`define TSC_VB_LSB            18
`define TSC_VB_ADDR_MSB       31
`define TSC_VB_ADDR_LSB       16
`define TSC_VB_WMASK          32'hfffc0000
`define TSC_VB_RST            32'h00000000

// ==========================================================================
// Tile feature control
`define TSC_CTRL_DLY_MSB      25
`define TSC_CTRL_DLY_LSB      18
`define TSC_CTRL_DIV_MSB      17
`define TSC_CTRL_DIV_LSB      9
`define TSC_CTRL_RGMII_EN     8
`define TSC_CTRL_DYN_MODE     5
`define TSC_CTRL_CLKDIV_EN    4
`define TSC_CTRL_USB_UTMI     2
`define TSC_CTRL_USB_ULPI_EN  1
`define TSC_CTRL_WMASK        32'h03ffff36
`define TSC_CTRL_RST          32'h00000000

// ==========================================================================
// Boot status
`define TSC_BOOT_PROC_MSB     23
`define TSC_BOOT_PROC_LSB     16
`define TSC_BOOT_OVERRIDE     8
`define TSC_BOOT_CORE1_PWR    5
`define TSC_BOOT_OTP_NOPOLL   4
`define TSC_BOOT_FROM_RAM     3
`define TSC_BOOT_FROM_JTAG    2
`define TSC_BOOT_PLL_MSB      1
`define TSC_BOOT_PLL_LSB      0
`define TSC_STRAP_WAIT        2'h3

// ==========================================================================
// Security settings
`define TSC_SEC_WR_LOCK       31
`define TSC_SEC_GDBG_OFF      14
`define TSC_SEC_OTP_ALL_LOCK  12
`define TSC_SEC_SECT_MSB      11
`define TSC_SEC_SECT_LSB      8
`define TSC_SEC_OTP_REDUND    7
`define TSC_SEC_BOOT_OTP      5
`define TSC_SEC_PLL_JTAG_OFF  4
`define TSC_SEC_JTAG_TAP_OFF  0
`define TSC_SEC_WMASK         32'h80005fb1
`define TSC_SEC_RST           32'h00000000

// ==========================================================================
// Ring oscillators
`define TSC_OSC_CORE_RUN      1
`define TSC_OSC_PERIPH_RUN    0
`define TSC_OSC_WMASK         32'h00000003
`define TSC_OSC_RST           32'h00000000
`define TSC_OSC_CNT_W         16

`endif

//--- tsc_sync2.v
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps

module tsc_sync2 #(
  parameter WIDTH = 1
) (
  clk,
  rst_b,
  d_in,
  q_out
);
  input  wire             clk;
  input  wire             rst_b;
  input  wire [WIDTH-1:0] d_in;
  output wire [WIDTH-1:0] q_out;

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ==========================================================================
  // Synchroniser stages
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

//--- tsc_osc_counter.v
// Ring oscillator counter on the oscillator's own clock
`timescale 1ns/1ps
`include "tsc_defs.vh"

module tsc_osc_counter (
  osc_clk,
  por_b,
  run,
  count
);
  input  wire                     osc_clk;
  input  wire                     por_b;
  input  wire                     run;
  output wire [`TSC_OSC_CNT_W-1:0] count;

  wire                      run_s;
  reg  [`TSC_OSC_CNT_W-1:0] count_r;

  // ==========================================================================
  // Run enable into the oscillator domain
  tsc_sync2 #(
    .WIDTH (1)
  ) u_run_sync (
    .clk   (osc_clk),
    .rst_b (por_b),
    .d_in  (run),
    .q_out (run_s)
  );

  // ==========================================================================
  // Counter, cleared only at power-on
  always @(posedge osc_clk or negedge por_b) begin
    if (!por_b) begin
      count_r <= {`TSC_OSC_CNT_W{1'b0}};
    end else if (run_s) begin
      count_r <= count_r + {{(`TSC_OSC_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign count = count_r;

endmodule

//--- tsc_regs.v
// Tile status and configuration register bank
`timescale 1ns/1ps
`include "tsc_defs.vh"

module tsc_regs (
  mclk,
  rst_b,
  por_b,
  ps_wr_en,
  ps_rd_en,
  ps_addr,
  ps_wdata,
  ps_rdata,
  ps_rd_valid,
  evt_req,
  evt_vector,
  evt_target_addr,
  evt_target_valid,
  threads_all_paused,
  rgmii_tx_delay,
  rgmii_tx_clk_div,
  rgmii_enable,
  rgmii_tx_clk,
  clk_div_dynamic,
  clk_div_en,
  clk_div_active,
  usb_utmi_sel,
  usb_ulpi_en,
  processor_id,
  boot_from_ram,
  boot_from_jtag,
  pll_strap_pins,
  second_core_power_state,
  otp_poll_skip,
  boot_mode_override,
  otp_sec_load,
  otp_sec_word,
  sec_write_lock,
  sec_global_debug_off,
  sec_otp_all_lock,
  sec_otp_sector_lock,
  sec_otp_redundancy,
  sec_boot_from_otp,
  sec_pll_jtag_off,
  sec_jtag_tap_off,
  core_osc_run,
  periph_osc_run,
  osc_clk_tile_cell
);
  input  wire        mclk;
  input  wire        rst_b;
  input  wire        por_b;
  input  wire        ps_wr_en;
  input  wire        ps_rd_en;
  input  wire [7:0]  ps_addr;
  input  wire [31:0] ps_wdata;
  output wire [31:0] ps_rdata;
  output wire        ps_rd_valid;
  input  wire        evt_req;
  input  wire [15:0] evt_vector;
  output wire [31:0] evt_target_addr;
  output wire        evt_target_valid;
  input  wire        threads_all_paused;
  output wire [7:0]  rgmii_tx_delay;
  output wire [8:0]  rgmii_tx_clk_div;
  output wire        rgmii_enable;
  output wire        rgmii_tx_clk;
  output wire        clk_div_dynamic;
  output wire        clk_div_en;
  output wire        clk_div_active;
  output wire        usb_utmi_sel;
  output wire        usb_ulpi_en;
  input  wire [7:0]  processor_id;
  input  wire        boot_from_ram;
  input  wire        boot_from_jtag;
  input  wire [1:0]  pll_strap_pins;
  input  wire        second_core_power_state;
  input  wire        otp_poll_skip;
  input  wire        boot_mode_override;
  input  wire        otp_sec_load;
  input  wire [31:0] otp_sec_word;
  output wire        sec_write_lock;
  output wire        sec_global_debug_off;
  output wire        sec_otp_all_lock;
  output wire [3:0]  sec_otp_sector_lock;
  output wire        sec_otp_redundancy;
  output wire        sec_boot_from_otp;
  output wire        sec_pll_jtag_off;
  output wire        sec_jtag_tap_off;
  output wire        core_osc_run;
  output wire        periph_osc_run;
  input  wire        osc_clk_tile_cell;

  // ==========================================================================
  // Storage
  reg  [31:0]               vb_r;
  reg  [31:0]               ctrl_r;
  reg  [31:0]               sec_r;
  reg  [31:0]               osc_r;
  reg  [31:0]               rdata_r;
  reg                       rd_valid_r;
  reg  [31:0]               rd_mux;
  reg  [31:0]               boot_word;
  reg  [31:0]               evt_addr_r;
  reg                       evt_valid_r;
  reg  [8:0]                txc_cnt_r;
  reg                       txc_r;
  reg                       div_act_r;
  reg  [1:0]                strap_r;
  reg  [1:0]                strap_wait_r;
  wire [1:0]                strap_s;
  wire [`TSC_OSC_CNT_W-1:0] osc_cnt_raw;
  wire [`TSC_OSC_CNT_W-1:0] osc_cnt_s;
  wire [8:0]                div_val;
  wire [8:0]                div_half;

  // ==========================================================================
  // Write decode
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vb_r   <= `TSC_VB_RST;
      ctrl_r <= `TSC_CTRL_RST;
      osc_r  <= `TSC_OSC_RST;
    end else if (ps_wr_en) begin
      if (ps_addr == `TSC_REG_EVT_BASE) begin
        vb_r <= ps_wdata & `TSC_VB_WMASK;
      end else if (ps_addr == `TSC_REG_TILE_CTRL) begin
        ctrl_r <= ps_wdata & `TSC_CTRL_WMASK;
      end else if (ps_addr == `TSC_REG_OSC_CTRL) begin
        osc_r <= ps_wdata & `TSC_OSC_WMASK;
      end
    end
  end

  // ==========================================================================
  // Security settings: OTP copy, write lock
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sec_r <= `TSC_SEC_RST;
    end else if (otp_sec_load) begin
      sec_r <= otp_sec_word & `TSC_SEC_WMASK;
    end else if (ps_wr_en && (ps_addr == `TSC_REG_SECURITY) &&
                 !sec_r[`TSC_SEC_WR_LOCK]) begin
      sec_r <= ps_wdata & `TSC_SEC_WMASK;
    end
  end

  assign sec_write_lock       = sec_r[`TSC_SEC_WR_LOCK];
  assign sec_global_debug_off = sec_r[`TSC_SEC_GDBG_OFF];
  assign sec_otp_all_lock     = sec_r[`TSC_SEC_OTP_ALL_LOCK];
  assign sec_otp_sector_lock  = sec_r[`TSC_SEC_SECT_MSB:`TSC_SEC_SECT_LSB];
  assign sec_otp_redundancy   = sec_r[`TSC_SEC_OTP_REDUND];
  assign sec_boot_from_otp    = sec_r[`TSC_SEC_BOOT_OTP];
  assign sec_pll_jtag_off     = sec_r[`TSC_SEC_PLL_JTAG_OFF];
  assign sec_jtag_tap_off     = sec_r[`TSC_SEC_JTAG_TAP_OFF];

  // ==========================================================================
  // Tile feature control outputs
  assign rgmii_tx_delay   = ctrl_r[`TSC_CTRL_DLY_MSB:`TSC_CTRL_DLY_LSB];
  assign rgmii_tx_clk_div = ctrl_r[`TSC_CTRL_DIV_MSB:`TSC_CTRL_DIV_LSB];
  assign rgmii_enable     = ctrl_r[`TSC_CTRL_RGMII_EN];
  assign clk_div_dynamic  = ctrl_r[`TSC_CTRL_DYN_MODE];
  assign clk_div_en       = ctrl_r[`TSC_CTRL_CLKDIV_EN];
  assign usb_utmi_sel     = ctrl_r[`TSC_CTRL_USB_UTMI];
  assign usb_ulpi_en      = ctrl_r[`TSC_CTRL_USB_ULPI_EN];

  // ==========================================================================
  // Low-power divider activation
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_act_r <= 1'b0;
    end else begin
      div_act_r <= clk_div_en & (~clk_div_dynamic | threads_all_paused);
    end
  end

  assign clk_div_active = div_act_r;

  // ==========================================================================
  // RGMII transmit clock generator
  assign div_val  = rgmii_tx_clk_div;
  assign div_half = {1'b0, div_val[8:1]};

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txc_cnt_r <= 9'h000;
      txc_r     <= 1'b0;
    end else if (!rgmii_enable) begin
      txc_cnt_r <= 9'h000;
      txc_r     <= 1'b0;
    end else if (txc_cnt_r >= div_val) begin
      txc_cnt_r <= 9'h000;
      txc_r     <= 1'b1;
    end else begin
      txc_cnt_r <= txc_cnt_r + 9'h001;
      if (txc_cnt_r == div_half) begin
        txc_r <= 1'b0;
      end
    end
  end

  assign rgmii_tx_clk = txc_r;

  // ==========================================================================
  // Event target address
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evt_addr_r  <= 32'h00000000;
      evt_valid_r <= 1'b0;
    end else begin
      evt_valid_r <= evt_req;
      if (evt_req) begin
        evt_addr_r <= {vb_r[`TSC_VB_ADDR_MSB:`TSC_VB_ADDR_LSB], evt_vector};
      end
    end
  end

  assign evt_target_addr  = evt_addr_r;
  assign evt_target_valid = evt_valid_r;

  // ==========================================================================
  // PLL strap pins, sampled once after reset
  tsc_sync2 #(
    .WIDTH (2)
  ) u_strap_sync (
    .clk   (mclk),
    .rst_b (rst_b),
    .d_in  (pll_strap_pins),
    .q_out (strap_s)
  );

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_wait_r <= 2'h0;
      strap_r      <= 2'h0;
    end else if (strap_wait_r != `TSC_STRAP_WAIT) begin
      strap_wait_r <= strap_wait_r + 2'h1;
      if (strap_wait_r == (`TSC_STRAP_WAIT - 2'h1)) begin
        strap_r <= strap_s;
      end
    end
  end

  // ==========================================================================
  // Boot status word
  always @* begin
    boot_word = 32'h00000000;
    boot_word[`TSC_BOOT_PROC_MSB:`TSC_BOOT_PROC_LSB] = processor_id;
    boot_word[`TSC_BOOT_OVERRIDE]   = boot_mode_override;
    boot_word[`TSC_BOOT_CORE1_PWR]  = second_core_power_state;
    boot_word[`TSC_BOOT_OTP_NOPOLL] = otp_poll_skip;
    boot_word[`TSC_BOOT_FROM_RAM]   = boot_from_ram;
    boot_word[`TSC_BOOT_FROM_JTAG]  = boot_from_jtag;
    boot_word[`TSC_BOOT_PLL_MSB:`TSC_BOOT_PLL_LSB] = strap_r;
  end

  // ==========================================================================
  // Ring oscillator control and first counter
  assign core_osc_run   = osc_r[`TSC_OSC_CORE_RUN];
  assign periph_osc_run = osc_r[`TSC_OSC_PERIPH_RUN];

  tsc_osc_counter u_osc_cnt0 (
    .osc_clk (osc_clk_tile_cell),
    .por_b   (por_b),
    .run     (core_osc_run),
    .count   (osc_cnt_raw)
  );

  tsc_sync2 #(
    .WIDTH (`TSC_OSC_CNT_W)
  ) u_cnt_sync (
    .clk   (mclk),
    .rst_b (por_b),
    .d_in  (osc_cnt_raw),
    .q_out (osc_cnt_s)
  );

  // ==========================================================================
  // Read decode
  always @* begin
    rd_mux = 32'h00000000;
    if (ps_addr == `TSC_REG_EVT_BASE) begin
      rd_mux = vb_r;
    end else if (ps_addr == `TSC_REG_TILE_CTRL) begin
      rd_mux = ctrl_r;
    end else if (ps_addr == `TSC_REG_BOOT_STATUS) begin
      rd_mux = boot_word;
    end else if (ps_addr == `TSC_REG_SECURITY) begin
      rd_mux = sec_r;
    end else if (ps_addr == `TSC_REG_OSC_CTRL) begin
      rd_mux = osc_r;
    end else if (ps_addr == `TSC_REG_OSC_COUNT0) begin
      rd_mux = {{(32-`TSC_OSC_CNT_W){1'b0}}, osc_cnt_s};
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r    <= 32'h00000000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= ps_rd_en;
      if (ps_rd_en) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign ps_rdata    = rdata_r;
  assign ps_rd_valid = rd_valid_r;

endmodule

//--- tsc_regs_asserts.sv
// Assertion checker for the tile status register bank
`timescale 1ns/1ps
module tsc_regs_asserts (
  input wire        mclk,
  input wire        rst_b,
  input wire        ps_wr_en,
  input wire        ps_rd_en,
  input wire [7:0]  ps_addr,
  input wire [31:0] ps_wdata,
  input wire [31:0] ps_rdata,
  input wire        ps_rd_valid,
  input wire        evt_req,
  input wire [15:0] evt_vector,
  input wire [31:0] evt_target_addr,
  input wire        evt_target_valid,
  input wire        threads_all_paused,
  input wire        rgmii_enable,
  input wire        rgmii_tx_clk,
  input wire        clk_div_dynamic,
  input wire        clk_div_en,
  input wire        clk_div_active,
  input wire        otp_sec_load,
  input wire [31:0] otp_sec_word,
  input wire        sec_write_lock,
  input wire [3:0]  sec_otp_sector_lock,
  input wire        core_osc_run,
  input wire        periph_osc_run
);
  // ==========================================================================
  // Delayed copies of inputs
  logic [31:0] wd_r;
  logic [31:0] otp_r;
  logic [15:0] vec_r;
  always_ff @(posedge mclk) begin
    wd_r  <= ps_wdata;
    otp_r <= otp_sec_word;
    vec_r <= evt_vector;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Properties
  property p_vb_rsvd;
    ps_rd_en && ps_addr == 8'h01 |=> ps_rd_valid && ps_rdata[17:0] == 18'h0;
  endproperty
  a_vb_rsvd: assert property (p_vb_rsvd) else $error("vector base low bits");
  property p_evt;
    evt_req |=> evt_target_valid && evt_target_addr[15:0] == vec_r
      && evt_target_addr[17:16] == 2'h0;
  endproperty
  a_evt: assert property (p_evt) else $error("event target wrong");
  property p_rgmii_off;
    !rgmii_enable |=> !rgmii_tx_clk;
  endproperty
  a_rgmii_off: assert property (p_rgmii_off) else $error("tx clock while off");
  property p_ctrl_wr;
    ps_wr_en && ps_addr == 8'h02 |=> rgmii_enable == wd_r[8]
      && clk_div_dynamic == wd_r[5] && clk_div_en == wd_r[4];
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control bits wrong");
  property p_div_static;
    clk_div_en && !clk_div_dynamic |=> clk_div_active;
  endproperty
  a_div_static: assert property (p_div_static) else $error("static divider idle");
  property p_div_dyn;
    clk_div_en && clk_div_dynamic |=> clk_div_active == $past(threads_all_paused);
  endproperty
  a_div_dyn: assert property (p_div_dyn) else $error("dynamic divider wrong");
  property p_div_off;
    !clk_div_en |=> !clk_div_active;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider active while off");
  property p_sec_load;
    otp_sec_load |=> sec_write_lock == otp_r[31] && sec_otp_sector_lock == otp_r[11:8];
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security load wrong");
  property p_sec_lock;
    sec_write_lock && ps_wr_en && !otp_sec_load |=> sec_write_lock
      && $stable(sec_otp_sector_lock);
  endproperty
  a_sec_lock: assert property (p_sec_lock) else $error("locked security changed");
  property p_osc_wr;
    ps_wr_en && ps_addr == 8'h06 |=> core_osc_run == wd_r[1] && periph_osc_run == wd_r[0];
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("oscillator run bits wrong");
endmodule

bind tsc_regs tsc_regs_asserts u_chk (
  .mclk(mclk), .rst_b(rst_b), .ps_wr_en(ps_wr_en), .ps_rd_en(ps_rd_en),
  .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rd_valid(ps_rd_valid),
  .evt_req(evt_req), .evt_vector(evt_vector), .evt_target_addr(evt_target_addr),
  .evt_target_valid(evt_target_valid), .threads_all_paused(threads_all_paused),
  .rgmii_enable(rgmii_enable), .rgmii_tx_clk(rgmii_tx_clk),
  .clk_div_dynamic(clk_div_dynamic), .clk_div_en(clk_div_en),
  .clk_div_active(clk_div_active), .otp_sec_load(otp_sec_load),
  .otp_sec_word(otp_sec_word), .sec_write_lock(sec_write_lock),
  .sec_otp_sector_lock(sec_otp_sector_lock), .core_osc_run(core_osc_run),
  .periph_osc_run(periph_osc_run));

//--- tb_tsc_regs.sv
// Self-checking bench for the tile status register bank
`timescale 1ns/1ps
module tb_tsc_regs;
  // ==========================================================================
  // Signals
  logic        mclk, rst_b, por_b, ps_wr_en, ps_rd_en, ps_rd_valid, osc_clk;
  logic [7:0]  ps_addr, processor_id, tx_dly;
  logic [31:0] ps_wdata, ps_rdata, evt_addr, otp_sec_word;
  logic [15:0] evt_vector;
  logic [8:0]  tx_div;
  logic [3:0]  sect;
  logic [1:0]  pll_strap_pins;
  logic        evt_req, evt_valid, paused, rg_en, rg_clk, dyn, dv_en, dv_act;
  logic        utmi, ulpi, b_ram, b_jtag, b_pwr, b_nopoll, b_ovr, otp_sec_load;
  logic        s_lock, s_gdbg, s_all, s_red, s_boot, s_pll, s_tap, c_run, p_run;
  int          err_total, n_compared, cyc;

  tsc_regs dut_u (
    .mclk(mclk), .rst_b(rst_b), .por_b(por_b), .ps_wr_en(ps_wr_en), .ps_rd_en(ps_rd_en),
    .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rd_valid(ps_rd_valid),
    .evt_req(evt_req), .evt_vector(evt_vector), .evt_target_addr(evt_addr),
    .evt_target_valid(evt_valid), .threads_all_paused(paused), .rgmii_tx_delay(tx_dly),
    .rgmii_tx_clk_div(tx_div), .rgmii_enable(rg_en), .rgmii_tx_clk(rg_clk),
    .clk_div_dynamic(dyn), .clk_div_en(dv_en), .clk_div_active(dv_act),
    .usb_utmi_sel(utmi), .usb_ulpi_en(ulpi), .processor_id(processor_id),
    .boot_from_ram(b_ram), .boot_from_jtag(b_jtag), .pll_strap_pins(pll_strap_pins),
    .second_core_power_state(b_pwr), .otp_poll_skip(b_nopoll), .boot_mode_override(b_ovr),
    .otp_sec_load(otp_sec_load), .otp_sec_word(otp_sec_word), .sec_write_lock(s_lock),
    .sec_global_debug_off(s_gdbg), .sec_otp_all_lock(s_all), .sec_otp_sector_lock(sect),
    .sec_otp_redundancy(s_red), .sec_boot_from_otp(s_boot), .sec_pll_jtag_off(s_pll),
    .sec_jtag_tap_off(s_tap), .core_osc_run(c_run), .periph_osc_run(p_run),
    .osc_clk_tile_cell(osc_clk));

  // ==========================================================================
  // Clocks and timeout
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    osc_clk = 1'b0;
    #1.3;
    forever #3.5 osc_clk = ~osc_clk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ps_wr_en = 1'b1;
    ps_addr = a;
    ps_wdata = d;
    @(negedge mclk);
    ps_wr_en = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ps_rd_en = 1'b1;
    ps_addr = a;
    @(negedge mclk);
    ps_rd_en = 1'b0;
    v = ps_rd_valid === 1'b1 ? ps_rdata : 32'hxxxxxxxx;
    @(negedge mclk);
  endtask
  task automatic ld(input logic [31:0] w);
    otp_sec_word = w;
    otp_sec_load = 1'b1;
    @(negedge mclk);
    otp_sec_load = 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    logic [31:0] v;
    logic [7:0]  a [5] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h04};
    wr(8'h04, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      rd(a[i], v);
      chk(v, 32'h0);
    end
  endtask
  task automatic t_vector;
    logic [31:0] v;
    wr(8'h01, 32'hffffffff);
    rd(8'h01, v);
    chk(v, 32'hfffc0000);
    evt_req = 1'b1;
    evt_vector = 16'h1234;
    @(negedge mclk);
    chk({evt_valid, evt_addr}, {1'b1, 32'hfffc1234});
    evt_vector = 16'hbeef;
    @(negedge mclk);
    chk({evt_valid, evt_addr}, {1'b1, 32'hfffcbeef});
    evt_req = 1'b0;
  endtask
  task automatic t_ctrl;
    logic [31:0] v;
    wr(8'h02, 32'hffffffff);
    rd(8'h02, v);
    chk(v, 32'h03ffff36);
    chk({tx_dly, tx_div, rg_en, dyn, dv_en, utmi, ulpi}, 32'h003fffff);
    wr(8'h02, 32'h01694a22);
    rd(8'h02, v);
    chk(v, 32'h01694a22);
    chk({tx_dly, tx_div, rg_en, dyn, dv_en, utmi, ulpi}, {8'h5a, 9'h0a5, 5'b01001});
  endtask
  task automatic t_divider;
    logic [31:0] w [4] = '{32'h0, 32'h10, 32'h30, 32'h30};
    logic [3:0]  e = 4'b1010;
    for (int i = 0; i < 4; i++) begin
      paused = (i == 3);
      wr(8'h02, w[i]);
      @(negedge mclk);
      chk(dv_act, e[i]);
    end
  endtask
  task automatic t_rgmii;
    int p;
    int n;
    logic prev;
    p = -1;
    n = 0;
    wr(8'h02, 32'h00000700);
    for (int i = 0; i < 30; i++) begin
      prev = rg_clk;
      @(negedge mclk);
      if (prev === 1'b0 && rg_clk === 1'b1) begin
        if (p >= 0) n = i - p;
        p = i;
      end
    end
    chk(n, 4);
    wr(8'h02, 32'h0);
    repeat (2) @(negedge mclk);
    chk(rg_clk, 1'b0);
  endtask
  task automatic t_boot;
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      processor_id = i ? 8'h5a : 8'ha5;
      {b_ram, b_jtag, b_pwr, b_nopoll, b_ovr} = i ? 5'b01010 : 5'b10101;
      wr(8'h03, 32'hffffffff);
      rd(8'h03, v);
      chk(v, i ? 32'h005a0016 : 32'h00a5012a);
    end
  endtask
  task automatic t_sec;
    logic [31:0] v;
    logic [31:0] w [2] = '{32'h00004a91, 32'h00001520};
    logic [10:0] e [2] = '{11'b01010101011, 11'b00101010100};
    ld(32'hffffffff);
    wr(8'h05, 32'h0);
    rd(8'h05, v);
    chk(v, 32'h80005fb1);
    ld(32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(8'h05, w[i]);
      chk({s_lock, s_gdbg, s_all, sect, s_red, s_boot, s_pll, s_tap}, e[i]);
    end
  endtask
  task automatic t_osc;
    logic [31:0] v;
    logic [31:0] c1;
    wr(8'h06, 32'hffffffff);
    rd(8'h06, v);
    chk(v, 32'h3);
    repeat (40) @(negedge mclk);
    wr(8'h06, 32'h1);
    chk({c_run, p_run}, 2'b01);
    repeat (20) @(negedge mclk);
    rd(8'h07, c1);
    chk({31'h0, c1 >= 32'd40 && c1 <= 32'd80}, 32'h1);
    repeat (20) @(negedge mclk);
    rd(8'h07, v);
    chk(v, c1);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (5) @(negedge mclk);
    rd(8'h07, v);
    chk(v, c1);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_b, por_b, ps_wr_en, ps_rd_en, evt_req, paused, otp_sec_load} = 7'h0;
    {ps_addr, ps_wdata, evt_vector, otp_sec_word, processor_id} = 96'h0;
    {b_ram, b_jtag, b_pwr, b_nopoll, b_ovr} = 5'h0;
    pll_strap_pins = 2'b10;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    por_b = 1'b1;
    repeat (5) @(negedge mclk);
    t_defaults();
    t_vector();
    t_ctrl();
    t_divider();
    t_rgmii();
    t_boot();
    t_sec();
    t_osc();
    summarize();
  end
endmodule
